// >>> hdl/read_limit_consts.svh
`ifndef READ_LIMIT_CONSTS_SVH
`define READ_LIMIT_CONSTS_SVH

`define ACCESS_LIMIT_ADDR  8'hB7
`define ACCESS_LIMIT_RESET 8'h00
`define LIMIT_LOW_BYTE     8'h00
`define BLOCKED_DATA       8'h00
`define IDLE_DATA          8'h00

`endif

// >>> hdl/read_limit_pkg.sv
package read_limit_pkg;
  typedef enum logic [1:0] {
    LOCK_OPEN = 2'b01,
    LOCK_SET  = 2'b10
  } lock_state_t;
endpackage

// >>> hdl/partition_compare.sv
`timescale 1ns/1ps
`include "read_limit_consts.svh"
module partition_compare #(
  parameter int ADDR_W = 16
) (
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [ADDR_W-1:0] limit_i,
  output logic                   lower_o
);
  // Lower partition runs from zero up to, not including, the limit
  assign lower_o = (addr_i < limit_i);
endmodule

// >>> hdl/program_memory_read_limit.sv
`timescale 1ns/1ps
`include "read_limit_consts.svh"
module program_memory_read_limit
  import read_limit_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic [ADDR_W-1:0] exec_pc_i,
  input  wire logic              fetch_req_i,
  input  wire logic [ADDR_W-1:0] fetch_addr_i,
  input  wire logic              code_rd_req_i,
  input  wire logic [ADDR_W-1:0] code_rd_addr_i,
  input  wire logic [7:0]        flash_rdata_i,
  output logic                   fetch_grant_o,
  output logic      [7:0]        code_rd_data_o,
  output logic                   code_rd_valid_o,
  input  wire logic              flash_wr_req_i,
  input  wire logic [ADDR_W-1:0] flash_wr_addr_i,
  output logic                   flash_wr_en_o,
  output logic                   flash_wr_blocked_o,
  output logic      [ADDR_W-1:0] software_read_limit_o
);
  localparam int CMP_N    = 4;
  localparam int CMP_PC   = 0;
  localparam int CMP_SRC  = 1;
  localparam int CMP_WR   = 2;
  localparam int CMP_FTCH = 3;

  logic [7:0]        access_limit_high_byte;
  lock_state_t       lock_state;
  lock_state_t       next_lock_state;
  logic [ADDR_W-1:0] cmp_addr [CMP_N];
  logic [CMP_N-1:0]  cmp_lower;
  logic              pc_lower;
  logic              src_lower;
  logic              wr_lower;
  logic              fetch_lower;
  logic              reg_hit;
  logic              reg_read_hit;
  logic              write_take;
  logic              rd_block;
  logic              wr_block;
  logic [ADDR_W-1:0] limit;
  logic [7:0]        next_rd_data;
  logic [7:0]        next_reg_rdata;
  logic [7:0]        next_code_rd_data;
  logic              next_wr_en;
  logic              next_wr_blocked;

  // Limit sits on a 256-byte grain: stored byte high, low byte zero
  assign limit        = {access_limit_high_byte, `LIMIT_LOW_BYTE};
  assign reg_hit      = (reg_addr_i == `ACCESS_LIMIT_ADDR);
  assign reg_read_hit = reg_rd_i && reg_hit;
  assign write_take   = reg_wr_i && reg_hit && (lock_state == LOCK_OPEN);

  // Every address that is placed against the limit gets its own comparator
  assign cmp_addr[CMP_PC]   = exec_pc_i;
  assign cmp_addr[CMP_SRC]  = code_rd_addr_i;
  assign cmp_addr[CMP_WR]   = flash_wr_addr_i;
  assign cmp_addr[CMP_FTCH] = fetch_addr_i;

  for (genvar i = 0; i < CMP_N; i++) begin : g_cmp
    partition_compare #(
      .ADDR_W(ADDR_W)
    ) u_cmp (
      .addr_i  (cmp_addr[i]),
      .limit_i (limit),
      .lower_o (cmp_lower[i])
    );
  end

  assign pc_lower    = cmp_lower[CMP_PC];
  assign src_lower   = cmp_lower[CMP_SRC];
  assign wr_lower    = cmp_lower[CMP_WR];
  assign fetch_lower = cmp_lower[CMP_FTCH];

  // Only code running at or above the limit is fenced off from the protected part
  assign rd_block          = !pc_lower && src_lower;
  assign wr_block          = !pc_lower && wr_lower;
  assign next_rd_data      = rd_block ? `BLOCKED_DATA : flash_rdata_i;
  assign next_code_rd_data = code_rd_req_i ? next_rd_data : `IDLE_DATA;
  assign next_reg_rdata    = reg_read_hit ? access_limit_high_byte : `IDLE_DATA;
  assign next_wr_en        = flash_wr_req_i && !wr_block;
  assign next_wr_blocked   = flash_wr_req_i && wr_block;

  // One-shot lock: the first accepted write closes the register until reset
  always_comb begin
    case (lock_state)
      LOCK_OPEN: begin
        next_lock_state = write_take ? LOCK_SET : LOCK_OPEN;
      end
      LOCK_SET: begin
        next_lock_state = LOCK_SET;
      end
      default: begin
        // An illegal code keeps the register shut rather than reopening it
        next_lock_state = LOCK_SET;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_state <= LOCK_OPEN;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      access_limit_high_byte <= `ACCESS_LIMIT_RESET;
    end else if (write_take) begin
      access_limit_high_byte <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `IDLE_DATA;
    end else begin
      reg_rdata_o <= next_reg_rdata;
    end
  end

  // Fetches are never held against the limit, so calls into protected code run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_grant_o <= 1'b0;
    end else begin
      fetch_grant_o <= fetch_req_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_rd_data_o  <= `IDLE_DATA;
      code_rd_valid_o <= 1'b0;
    end else begin
      code_rd_data_o  <= next_code_rd_data;
      code_rd_valid_o <= code_rd_req_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_wr_en_o      <= 1'b0;
      flash_wr_blocked_o <= 1'b0;
    end else begin
      flash_wr_en_o      <= next_wr_en;
      flash_wr_blocked_o <= next_wr_blocked;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      software_read_limit_o <= '0;
    end else begin
      software_read_limit_o <= limit;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_read_blocked: assert property (
    code_rd_req_i && rd_block |=> code_rd_valid_o && code_rd_data_o == `BLOCKED_DATA)
    else $error("blocked read returned data");
  a_read_passes: assert property (
    code_rd_req_i && pc_lower |=> code_rd_data_o == $past(flash_rdata_i))
    else $error("lower partition read altered");
  a_fetch_granted: assert property (
    fetch_req_i |=> fetch_grant_o)
    else $error("fetch not granted");
  a_single_write: assert property (
    lock_state == LOCK_SET |=> $stable(access_limit_high_byte))
    else $error("limit changed after lock");
  a_first_write: assert property (
    write_take |=> access_limit_high_byte == $past(reg_wdata_i) ##1
      software_read_limit_o[ADDR_W-1 -: 8] == $past(reg_wdata_i, 2))
    else $error("first write not taken");
  a_low_byte_zero: assert property (
    software_read_limit_o[7:0] == `LIMIT_LOW_BYTE)
    else $error("limit low byte not zero");
  a_write_suppressed: assert property (
    flash_wr_req_i && wr_block |=> !flash_wr_en_o && flash_wr_blocked_o)
    else $error("protected write not suppressed");
  a_upper_read_ok: assert property (
    code_rd_req_i && !src_lower |=> code_rd_data_o == $past(flash_rdata_i))
    else $error("upper partition read altered");
  a_lock_closes: assert property (
    write_take |=> lock_state == LOCK_SET)
    else $error("lock not closed after first write");
  a_lock_holds: assert property (
    lock_state == LOCK_SET |=> lock_state == LOCK_SET)
    else $error("lock reopened without reset");
  a_lock_onehot: assert property (
    $onehot(lock_state))
    else $error("lock state code illegal");
  a_reg_readback: assert property (
    reg_read_hit |=> reg_rdata_o == $past(access_limit_high_byte))
    else $error("limit register readback wrong");
  a_reg_read_other: assert property (
    reg_rd_i && !reg_hit |=> reg_rdata_o == `IDLE_DATA)
    else $error("unmapped register read not zero");
  a_fetch_into_lower: assert property (
    fetch_req_i && !pc_lower && fetch_lower |=> fetch_grant_o)
    else $error("fetch into lower partition held");
  a_open_write_passes: assert property (
    flash_wr_req_i && !wr_block |=> flash_wr_en_o && !flash_wr_blocked_o)
    else $error("permitted write suppressed");
  a_zero_limit_open: assert property (
    code_rd_req_i && limit == '0 |=> code_rd_data_o == $past(flash_rdata_i))
    else $error("read altered with zero limit");

  c_block_read: cover property (code_rd_req_i && rd_block);
  c_lock_write: cover property (write_take ##[1:20] reg_wr_i && reg_hit);
  c_block_write: cover property (flash_wr_req_i && wr_block);
  c_fetch_into_lower: cover property (fetch_req_i && !pc_lower && fetch_lower);
  c_lower_read_upper: cover property (code_rd_req_i && pc_lower && !src_lower);
endmodule

// >>> tb/core_flash_model.sv
`timescale 1ns/1ps
module core_flash_model (
  input  wire logic [15:0] addr_i,
  output logic      [7:0]  data_o
);
  // Stored byte mixes both address bytes so a zeroed read stands out
  assign data_o = addr_i[15:8] ^ addr_i[7:0] ^ 8'h5A;
endmodule

// >>> tb/tb_program_memory_read_limit.sv
`timescale 1ns/1ps
module tb_program_memory_read_limit;
  logic        clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic        fetch_req_i = 0, code_rd_req_i = 0, flash_wr_req_i = 0;
  logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, flash_rdata_i, code_rd_data_o;
  logic [15:0] exec_pc_i = 0, fetch_addr_i = 0, code_rd_addr_i = 0, flash_wr_addr_i = 0, lim;
  logic        fetch_grant_o, code_rd_valid_o, flash_wr_en_o, flash_wr_blocked_o;
  int          n_errors = 0, samples_checked = 0;
  program_memory_read_limit i_dut (.clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .exec_pc_i, .fetch_req_i, .fetch_addr_i, .code_rd_req_i,
    .code_rd_addr_i, .flash_rdata_i, .fetch_grant_o, .code_rd_data_o, .code_rd_valid_o,
    .flash_wr_req_i, .flash_wr_addr_i, .flash_wr_en_o, .flash_wr_blocked_o,
    .software_read_limit_o(lim));
  core_flash_model i_flash (.addr_i(code_rd_addr_i), .data_o(flash_rdata_i));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [7:0] fb(logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    tick();
    reg_wr_i = 0;
    tick();
  endtask
  task automatic reg_rd(logic [7:0] a, logic [7:0] exp);
    {reg_rd_i, reg_addr_i} = {1'b1, a};
    tick();
    chk("reg_rdata", reg_rdata_o, exp);
    reg_rd_i = 0;
    tick();
  endtask
  // Code read from pc; each access also exercises a fetch of the same address that is read
  task automatic cr(logic [15:0] pc, logic [15:0] a, logic [7:0] exp);
    {exec_pc_i, code_rd_addr_i, fetch_addr_i} = {pc, a, a};
    {code_rd_req_i, fetch_req_i} = 2'b11;
    tick();
    chk("fetch_grant", fetch_grant_o, 1'b1);
    chk("rd_valid", code_rd_valid_o, 1'b1);
    chk("rd_data", code_rd_data_o, exp);
    {code_rd_req_i, fetch_req_i} = 2'b00;
    tick();
  endtask
  task automatic fw(logic [15:0] pc, logic [15:0] a, logic blk);
    {exec_pc_i, flash_wr_addr_i, flash_wr_req_i} = {pc, a, 1'b1};
    tick();
    chk("wr_en", flash_wr_en_o, !blk);
    chk("wr_blocked", flash_wr_blocked_o, blk);
    flash_wr_req_i = 0;
    tick();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1;
    tick();
    chk("limit", lim, 16'h0000);
    reg_rd(8'hB7, 8'h00);
    cr(16'h5000, 16'h1000, fb(16'h1000));
    reg_wr(8'hB6, 8'h20);
    reg_wr(8'hB7, 8'h40);
    chk("limit", lim, 16'h4000);
    reg_wr(8'hB7, 8'h80);
    chk("limit", lim, 16'h4000);
    reg_rd(8'hB7, 8'h40);
    reg_rd(8'hB6, 8'h00);
    cr(16'h5000, 16'h1000, 8'h00);
    cr(16'h4000, 16'h3FFF, 8'h00);
    cr(16'h5000, 16'h4000, fb(16'h4000));
    cr(16'h3FFF, 16'h1000, fb(16'h1000));
    cr(16'h3FFF, 16'h8000, fb(16'h8000));
    fw(16'h5000, 16'h3E00, 1'b1);
    fw(16'h5000, 16'h4200, 1'b0);
    fw(16'h1000, 16'h0200, 1'b0);
    rst_n_i = 0;
    tick();
    rst_n_i = 1;
    tick();
    chk("limit", lim, 16'h0000);
    reg_wr(8'hB7, 8'h02);
    chk("limit", lim, 16'h0200);
    report_and_stop();
  end
endmodule
